// ===== hdl/mfr_pkg.sv
/*
  constants and carriers for the manufacturer option command bank.
  assumes a byte-level management bus front end on the same 40 MHz clock.
*/
`default_nettype none
package mfr_pkg;
  // command codes
  localparam logic [7:0] CMD_VIN_OFFSET_TRIM_PAIR = 8'hdd;
  localparam logic [7:0] CMD_VOUT_TRIM_MONITOR = 8'hde;
  localparam logic [7:0] CMD_STARTUP_STATUS_LOG = 8'hdf;
  localparam logic [7:0] CMD_SPECIAL_OPTION_CONFIG = 8'he0;
  localparam logic [7:0] CMD_INTERNAL_TEMP_OFFSET = 8'he1;
  // block byte counts
  localparam logic [7:0] VIN_PAIR_BYTES = 8'h04;
  localparam logic [7:0] STATUS_LOG_BYTES = 8'h20;
  localparam logic [7:0] WORD_BYTES = 8'h02;
  localparam logic [7:0] UNMAPPED_READ = 8'hff;
  // special option field positions
  localparam int OPT_PEC_BIT = 7;
  localparam int OPT_HRR_BIT = 6;
  localparam int OPT_DROOP_BIT = 5;
  localparam int OPT_ART_BIT = 3;
  localparam int OPT_DBV_BIT = 2;
  localparam logic [7:0] OPT_WRITE_MASK = 8'hec;
  localparam logic [7:0] OPT_RESET = 8'h00;
  // pec
  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h40;
  // startup status log
  localparam int LOG_WORDS = 16;
  localparam int LOG_INTERVAL_S = 8;
  localparam int CLK_HZ = 40_000_000;
  localparam int unsigned LOG_INTERVAL_CYC = LOG_INTERVAL_S * CLK_HZ;

  typedef enum logic [1:0] {LOG_IDLE, LOG_RUN, LOG_DONE} mfr_log_state_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic wr_valid;
    logic [7:0] wr_data;
    logic rd_req;
  } mfr_req_t;

  typedef struct packed {
    logic pec_required;
    logic hybrid_ratio_regulation;
    logic droop_slope_select;
    logic adaptive_ramp_loop_comp;
    logic dynamic_bus_voltage;
  } mfr_opt_t;
endpackage : mfr_pkg
`default_nettype wire

// ===== hdl/mfr_option_regs.sv
/*
  manufacturer monitor and option command bank: offset and trim monitors,
  startup status log, special options byte with packet error checking.
  assumes the bus front end delivers command/data bytes and read requests
  as one-cycle strobes on this clock, and that the monitor inputs come
  from logic on the same clock.
*/
`default_nettype none
//
// Overview of operation
// - block read of vin offset pair: count 4, then off offset low, on offset high
// - word read of trim monitor returns signed output trim, low byte first
// - block read of status log: 32 bytes, word 0 first, word 15 last
// - log starts right after ramp done, one word each 8 s, sixteen words
// - option bit 7 set makes packet error check mandatory on writes
// - option bit 6 enables hybrid ratio regulation
// - option bit 5 picks droop slope: 0 linear, 1 non-linear
// - option bit 3 enables adaptive ramp with dynamic loop compensation
// - option bit 2 enables dynamic bus voltage
// - option bits 1 and 0 are reserved and do nothing
//
module mfr_option_regs
  import mfr_pkg::*;
#(
  parameter int unsigned LOG_INTERVAL_CYCLES = LOG_INTERVAL_CYC,
  parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire mfr_req_t bus_req,
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic comm_fault,
  input wire logic [15:0] vin_on_offset,
  input wire logic [15:0] vin_off_offset,
  input wire logic [15:0] vout_trim,
  input wire logic [15:0] temp_offset,
  input wire logic ramp_done,
  input wire logic [15:0] status_word,
  output mfr_opt_t opts
);

  ////////////////////////////////////////////////////////////////////////////
  // pec crc-8
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ((c << 1) ^ PEC_POLY) : (c << 1);
    end
    return c;
  endfunction : crc8

  localparam logic [7:0] CRC_SEED = crc8(8'h00, {DEV_ADDR, 1'b0});

  ////////////////////////////////////////////////////////////////////////////
  // transaction tracking
  logic [7:0] cmd;
  logic [1:0] wr_cnt;
  logic [7:0] wr_byte1;
  logic [7:0] crc;
  logic [5:0] rd_idx;
  logic [7:0] opt_reg;

  wire first_byte = bus_req.wr_valid && (wr_cnt == 2'd0);
  wire is_opt_cmd = (cmd == CMD_SPECIAL_OPTION_CONFIG);
  wire pec_ok = (wr_cnt == 2'd3) && (crc == 8'h00);
  wire plain_ok = (wr_cnt == 2'd2) && !opt_reg[OPT_PEC_BIT];
  wire opt_stop = bus_req.stop && is_opt_cmd && (wr_cnt >= 2'd2);
  // a pec byte, when present, must be right even if not required
  wire opt_accept = opt_stop && (pec_ok || plain_ok);
  wire opt_reject = opt_stop && !(pec_ok || plain_ok);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmd <= 8'h00;
      wr_cnt <= 2'd0;
      wr_byte1 <= 8'h00;
      crc <= 8'h00;
    end else if (bus_req.start) begin
      wr_cnt <= 2'd0;
      crc <= CRC_SEED;
    end else if (bus_req.wr_valid) begin
      if (first_byte) begin
        cmd <= bus_req.wr_data;
      end
      if (wr_cnt == 2'd1) begin
        wr_byte1 <= bus_req.wr_data;
      end
      if (wr_cnt != 2'd3) begin
        wr_cnt <= wr_cnt + 2'd1;
      end
      crc <= crc8(crc, bus_req.wr_data);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // special options byte
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      opt_reg <= OPT_RESET;
      comm_fault <= 1'b0;
    end else begin
      comm_fault <= opt_reject;
      if (opt_accept) begin
        opt_reg <= wr_byte1 & OPT_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      opts <= '0;
    end else begin
      opts.pec_required <= opt_reg[OPT_PEC_BIT];
      opts.hybrid_ratio_regulation <= opt_reg[OPT_HRR_BIT];
      opts.droop_slope_select <= opt_reg[OPT_DROOP_BIT];
      opts.adaptive_ramp_loop_comp <= opt_reg[OPT_ART_BIT];
      opts.dynamic_bus_voltage <= opt_reg[OPT_DBV_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // startup status log
  logic [15:0] log_mem [LOG_WORDS];
  mfr_log_state_t log_state;
  logic [28:0] log_timer;
  logic [3:0] log_slot;

  wire log_first = (log_state == LOG_IDLE) && ramp_done;
  wire log_tick = (log_state == LOG_RUN) &&
                  (log_timer == 29'(LOG_INTERVAL_CYCLES - 1));
  wire log_wr = log_first || log_tick;
  wire [3:0] log_wr_slot = log_first ? 4'h0 : log_slot;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      log_state <= LOG_IDLE;
      log_timer <= '0;
      log_slot <= 4'h0;
    end else begin
      unique case (log_state)
        LOG_IDLE: begin
          if (ramp_done) begin
            log_state <= LOG_RUN;
            log_slot <= 4'h1;
            log_timer <= '0;
          end
        end
        LOG_RUN: begin
          if (log_tick) begin
            log_timer <= '0;
            log_slot <= log_slot + 4'h1;
            if (log_slot == 4'(LOG_WORDS - 1)) begin
              log_state <= LOG_DONE;
            end
          end else begin
            log_timer <= log_timer + 29'd1;
          end
        end
        LOG_DONE: begin
          log_state <= LOG_DONE;
        end
      endcase
    end
  end

  genvar g;
  generate
    for (g = 0; g < LOG_WORDS; g++) begin : g_log
      always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
          log_mem[g] <= 16'h0000;
        end else if (log_wr && (log_wr_slot == 4'(g))) begin
          log_mem[g] <= status_word;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // read path: blocks lead with a byte count, data goes out lsb first
  logic [255:0] log_flat;
  generate
    for (g = 0; g < LOG_WORDS; g++) begin : g_flat
      assign log_flat[g*16 +: 16] = log_mem[g];
    end
  endgenerate

  wire [31:0] vin_pair = {vin_on_offset, vin_off_offset};
  wire [5:0] blk_idx = rd_idx - 6'd1;
  wire [7:0] blk_vin = (rd_idx == 6'd0) ? VIN_PAIR_BYTES :
                       (rd_idx <= 6'd4) ? vin_pair[blk_idx[1:0]*8 +: 8] : UNMAPPED_READ;
  wire [7:0] blk_log = (rd_idx == 6'd0) ? STATUS_LOG_BYTES :
                       (rd_idx <= 6'd32) ? log_flat[blk_idx[4:0]*8 +: 8] : UNMAPPED_READ;
  wire [7:0] word_trim = (rd_idx < 6'd2) ? vout_trim[rd_idx[0]*8 +: 8] : UNMAPPED_READ;
  wire [7:0] word_temp = (rd_idx < 6'd2) ? temp_offset[rd_idx[0]*8 +: 8] : UNMAPPED_READ;
  wire [7:0] byte_opt = (rd_idx == 6'd0) ? opt_reg : UNMAPPED_READ;
  wire [7:0] rd_sel =
    (cmd == CMD_VIN_OFFSET_TRIM_PAIR) ? blk_vin :
    (cmd == CMD_VOUT_TRIM_MONITOR) ? word_trim :
    (cmd == CMD_STARTUP_STATUS_LOG) ? blk_log :
    (cmd == CMD_SPECIAL_OPTION_CONFIG) ? byte_opt :
    (cmd == CMD_INTERNAL_TEMP_OFFSET) ? word_temp : UNMAPPED_READ;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_idx <= 6'd0;
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= bus_req.rd_req;
      if (bus_req.start) begin
        rd_idx <= 6'd0;
      end else if (bus_req.rd_req) begin
        rd_data <= rd_sel;
        // saturate so long reads keep returning filler
        if (rd_idx != 6'h3f) begin
          rd_idx <= rd_idx + 6'd1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_VIN_COUNT: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_VIN_OFFSET_TRIM_PAIR && rd_idx == 6'd0
    |=> rd_valid && rd_data == 8'h04) else $error("vin pair count wrong");
  AST_VIN_ORDER: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_VIN_OFFSET_TRIM_PAIR && rd_idx == 6'd4
    |=> rd_data == $past(vin_on_offset[15:8])) else $error("vin on offset not in top byte");
  AST_TRIM_HIGH: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_VOUT_TRIM_MONITOR && rd_idx == 6'd1
    |=> rd_data == $past(vout_trim[15:8])) else $error("trim high byte wrong");
  AST_LOG_LAST: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_STARTUP_STATUS_LOG && rd_idx == 6'd32
    |=> rd_data == $past(log_mem[15][15:8])) else $error("log word 15 not last");
  AST_LOG_FIRST: assert property (
    log_state == LOG_IDLE && ramp_done
    |=> log_mem[0] == $past(status_word) && log_slot == 4'h1 && log_state == LOG_RUN)
    else $error("log did not start at ramp done");
  AST_LOG_STEP: assert property (
    log_state == LOG_RUN && log_slot == 4'hf && log_tick
    |=> log_state == LOG_DONE && log_mem[15] == $past(status_word))
    else $error("log did not end after sixteen words");
  AST_PEC_SET: assert property (
    opt_accept && wr_byte1[7] |-> ##2 opts.pec_required) else $error("pec enable lost");
  AST_HRR_SET: assert property (
    opt_accept |-> ##2 opts.hybrid_ratio_regulation == $past(wr_byte1[6], 2))
    else $error("ratio mode not following bit 6");
  AST_DROOP_SET: assert property (
    opt_accept |-> ##2 opts.droop_slope_select == $past(wr_byte1[5], 2))
    else $error("droop slope not following bit 5");
  AST_ART_SET: assert property (
    opt_accept |-> ##2 opts.adaptive_ramp_loop_comp == $past(wr_byte1[3], 2))
    else $error("adaptive ramp not following bit 3");
  AST_DBV_SET: assert property (
    opt_accept |-> ##2 opts.dynamic_bus_voltage == $past(wr_byte1[2], 2))
    else $error("bus voltage not following bit 2");
  AST_RSVD_ZERO: assert property (
    opt_accept |=> opt_reg[1:0] == 2'b00) else $error("reserved bits stored");
  AST_PEC_REJECT: assert property (
    bus_req.stop && is_opt_cmd && opt_reg[OPT_PEC_BIT] && wr_cnt == 2'd2
    |=> comm_fault && $stable(opt_reg)) else $error("write without pec accepted");
  AST_RSVD_READ: assert property (
    bus_req.rd_req && !bus_req.start && is_opt_cmd && rd_idx == 6'd0
    |=> rd_data[1:0] == 2'b00) else $error("reserved bits read nonzero");
  AST_VIN_OFF_LOW: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_VIN_OFFSET_TRIM_PAIR && rd_idx == 6'd1
    |=> rd_data == $past(vin_off_offset[7:0])) else $error("vin off offset not first");
  AST_VIN_END: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_VIN_OFFSET_TRIM_PAIR && rd_idx == 6'd5
    |=> rd_data == UNMAPPED_READ) else $error("vin pair longer than four bytes");
  AST_TRIM_LOW: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_VOUT_TRIM_MONITOR && rd_idx == 6'd0
    |=> rd_valid && rd_data == $past(vout_trim[7:0])) else $error("trim low byte wrong");
  AST_LOG_COUNT: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_STARTUP_STATUS_LOG && rd_idx == 6'd0
    |=> rd_data == STATUS_LOG_BYTES) else $error("status log count wrong");
  AST_LOG_WORD0: assert property (
    bus_req.rd_req && !bus_req.start && cmd == CMD_STARTUP_STATUS_LOG && rd_idx == 6'd1
    |=> rd_data == $past(log_mem[0][7:0])) else $error("log word 0 not first");
  AST_LOG_HOLD: assert property (
    log_state == LOG_DONE |=> log_state == LOG_DONE && log_mem[15] == $past(log_mem[15]))
    else $error("log changed after sixteen words");
  AST_PEC_GOOD: assert property (
    bus_req.stop && is_opt_cmd && wr_cnt == 2'd3 && crc == 8'h00
    |=> !comm_fault && opt_reg == ($past(wr_byte1) & OPT_WRITE_MASK))
    else $error("write with good pec dropped");
  AST_PEC_BAD: assert property (
    bus_req.stop && is_opt_cmd && wr_cnt == 2'd3 && crc != 8'h00
    |=> comm_fault && $stable(opt_reg)) else $error("write with bad pec accepted");
  AST_OPT_HOLD: assert property (
    !opt_accept |=> $stable(opt_reg)) else $error("option byte changed without a write");

  COV_OPT_WRITE: cover property (opt_accept);
  COV_PEC_FAULT: cover property (comm_fault);
  COV_LOG_DONE: cover property (log_state == LOG_DONE);
  COV_LOG_READ: cover property (bus_req.rd_req && cmd == CMD_STARTUP_STATUS_LOG);

endmodule : mfr_option_regs
`default_nettype wire

// ===== verification/mfr_host_model.sv
/*
  host model: drives the byte strobes of the option command bank.
  assumes the bench calls its tasks one at a time, all on one clock.
*/
`default_nettype none
module mfr_host_model
  import mfr_pkg::*;
(
  input wire logic clock,
  input wire logic rd_valid,
  input wire logic [7:0] rd_data,
  input wire logic comm_fault,
  output mfr_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////
  initial req = '0;

  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++) r = r[7] ? ({r[6:0], 1'b0} ^ PEC_POLY) : {r[6:0], 1'b0};
    return r;
  endfunction : crc

  // one strobe set per cycle, launched just after the edge
  task automatic cyc(input logic s, p, v, input logic [7:0] d, input logic r);
    @(posedge clock);
    req <= '{start: s, stop: p, wr_valid: v, wr_data: d, rd_req: r};
  endtask : cyc

  // mode 0 no check byte, 1 good check byte, 2 corrupted one
  task automatic write(input logic [7:0] cmd, dat, input int mode, output logic flt);
    logic [7:0] c;
    c = crc(crc(crc(8'h00, {DEV_ADDR_DEFAULT, 1'b0}), cmd), dat);
    cyc(1, 0, 0, 8'h00, 0);
    cyc(0, 0, 1, cmd, 0);
    cyc(0, 0, 1, dat, 0);
    if (mode != 0) cyc(0, 0, 1, (mode == 1) ? c : ~c, 0);
    cyc(0, 1, 0, 8'h00, 0);
    cyc(0, 0, 0, 8'h00, 0);
    #1 flt = comm_fault;
    @(posedge clock);
  endtask : write

  // rd_valid lasts one cycle, so each byte is sampled right after its answer edge
  task automatic read(input logic [7:0] cmd, input int n, output logic [7:0] q[$]);
    q = {};
    cyc(1, 0, 0, 8'h00, 0);
    cyc(0, 0, 1, cmd, 0);
    cyc(1, 0, 0, 8'h00, 0);
    repeat (n) begin
      cyc(0, 0, 0, 8'h00, 1);
      cyc(0, 0, 0, 8'h00, 0);
      #1 q.push_back((rd_valid === 1'b1) ? rd_data : 8'hxx);
    end
    cyc(0, 1, 0, 8'h00, 0);
    cyc(0, 0, 0, 8'h00, 0);
  endtask : read
endmodule : mfr_host_model
`default_nettype wire

// ===== verification/mfr_monitor_option_regs_tb.sv
/*
  self-checking bench for the option command bank with a host model.
  assumes a shortened log interval; the status word is a cycle count.
*/
`default_nettype none
module mfr_monitor_option_regs_tb
  import mfr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IVL = 20;
  logic clock = 0, rst_b = 0, ramp_done = 0, rd_valid, comm_fault, flt;
  logic [15:0] von = '0, voff = '0, vtr = '0, tmp = '0, sw = '0, c0, w0;
  logic [7:0] rd_data, opt_m = '0;
  logic [7:0] q[$];
  mfr_req_t req;
  mfr_opt_t opts;
  int miscompares = 0, n_tests = 0, cycles = 0;
  ////////////////////////////////////////////////////////////////
  mfr_host_model host (.clock(clock), .rd_valid(rd_valid), .rd_data(rd_data),
    .comm_fault(comm_fault), .req(req));
  mfr_option_regs #(.LOG_INTERVAL_CYCLES(IVL)) DUT (.clock(clock), .rst_b(rst_b),
    .bus_req(req), .rd_valid(rd_valid), .rd_data(rd_data), .comm_fault(comm_fault),
    .vin_on_offset(von), .vin_off_offset(voff), .vout_trim(vtr), .temp_offset(tmp),
    .ramp_done(ramp_done), .status_word(sw), .opts(opts));

  initial forever #12.5 clock = ~clock;

  // timeout ceiling well above the seven hundred or so cycles the tests need
  always @(posedge clock) begin
    sw <= sw + 16'h0001;
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish

  // the bench's own option byte decides the expected fault and readback
  task automatic opt_wr(input logic [7:0] d, input int mode);
    logic ef;
    ef = (mode == 2) || (mode == 0 && opt_m[7]);
    host.write(CMD_SPECIAL_OPTION_CONFIG, d, mode, flt);
    check("fault", 16'(flt), 16'(ef));
    if (!ef) opt_m = d & 8'hec;
    host.read(CMD_SPECIAL_OPTION_CONFIG, 1, q);
    check("opt", 16'(q[0]), 16'(opt_m));
    check("opts", 16'(opts), 16'({opt_m[7:5], opt_m[3:2]}));
  endtask : opt_wr

  initial begin
    void'($urandom(32'h8cd6));
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    check("opts_rst", 16'(opts), 16'h0000);
    ramp_done <= 1'b1;
    c0 = sw;
    repeat (6) opt_wr(8'($urandom) & 8'h7f, 0);
    opt_wr(8'hff, 1);
    opt_wr(8'h20, 0);
    opt_wr(8'h24, 2);
    opt_wr(8'h00, 1);
    opt_wr(8'h24, 2);
    $display("test options done");
    von <= 16'($urandom);
    voff <= 16'($urandom);
    vtr <= 16'($urandom);
    tmp <= 16'($urandom);
    @(posedge clock);
    host.read(CMD_VIN_OFFSET_TRIM_PAIR, 5, q);
    check("vin_cnt", 16'(q[0]), 16'(VIN_PAIR_BYTES));
    check("vin_off", {q[2], q[1]}, voff);
    check("vin_on", {q[4], q[3]}, von);
    host.read(CMD_VOUT_TRIM_MONITOR, 2, q);
    check("trim", {q[1], q[0]}, vtr);
    host.read(CMD_INTERNAL_TEMP_OFFSET, 2, q);
    check("temp", {q[1], q[0]}, tmp);
    host.read(8'hd0, 1, q);
    check("unmapped", 16'(q[0]), 16'(UNMAPPED_READ));
    $display("test monitors done");
    // log runs fifteen intervals after ramp; wait past its end
    repeat (400) @(posedge clock);
    host.read(CMD_STARTUP_STATUS_LOG, 33, q);
    check("log_cnt", 16'(q[0]), 16'(STATUS_LOG_BYTES));
    // ramp_done is seen one edge after c0 was taken, so word 0 is c0 plus one
    w0 = c0 + 16'h0001;
    check("log_start", {q[2], q[1]}, w0);
    for (int k = 1; k < 16; k++) begin
      check("log_word", {q[2*k+2], q[2*k+1]}, w0 + 16'(k * IVL));
    end
    $display("test status log done");
    tally_and_finish();
  end
endmodule : mfr_monitor_option_regs_tb
`default_nettype wire
